/* src/tpg_pkg.sv */
// Purpose: constants and types for the timer pin control block
// Assumes: 32-bit classic Wishbone register access
// Notes:   one package, no imports
// Behaviour
// - Run-unhalted bit set keeps the counter running through any suspend.
// - Both select bits clear: counter stops one cycle after suspend is first seen.
// - Halt-at-period only: count on, stop once counter reaches the period.
// - Output-pin function bits 25/17 give the pin to general-purpose use.
// - Input-pin function bits 24/16 give the pin to general-purpose use.
// - Upper edge selects 13/12: zero means rising, one means falling.
// - Lower edge selects 5/4: zero means rising, one means falling.
// - An edge select matters only while its event-source bit is set.
// - Upper source bits 9/8 route events from pin edges; timer events pass only with all four source bits clear.
// - Lower source bits 1/0 route events from pin edges; timer events pass only with all four source bits clear.
// - All writable control bits reset to zero.
// - A pin in general-purpose use holds its timer half in reset.
package tpg_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  EMU_OFS     = 8'h04;
	localparam logic [7:0]  PIN_OFS     = 8'h08;
	localparam logic [7:0]  IRQ_STS_OFS = 8'h10;
	localparam logic [7:0]  IRQ_CLR_OFS = 8'h14;
	localparam logic [7:0]  IRQ_EN_OFS  = 8'h18;
	localparam logic [31:0] EMU_MASK    = 32'h0000_0003;
	localparam logic [31:0] PIN_MASK    = 32'h0303_3333;
	localparam logic [31:0] RST_VAL     = 32'h0000_0000;
	// Field positions
	localparam int FREE_BIT = 0;
	localparam int SOFT_BIT = 1;
	localparam int LO_GP    = 16;
	localparam int HI_GP    = 24;
	localparam int LO_SRC   = 0;
	localparam int HI_SRC   = 8;
	localparam int LO_INV   = 4;
	localparam int HI_INV   = 12;
	localparam int SYNC_LEN = 2;

	// Pin index order: 0 lower in, 1 lower out, 2 upper in, 3 upper out
	typedef struct packed {
		logic [3:0] pins;
	} tpg_pins_t;
endpackage

/* src/tpg_sync.sv */
// Purpose: two-flop synchroniser for the timer pins
// Assumes: pins are asynchronous to core_clk_i
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module tpg_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tpg_sync_t;
	tpg_sync_t r;
	tpg_sync_t next_r;

	// Shift chain
	always_comb begin
		next_r.s1 = d_i;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_o = r.s2;
endmodule

/* src/tpg_ctrl.sv */
// Purpose: emulation suspend and timer pin event control registers
// Assumes: classic Wishbone slave, one clock, pins asynchronous
// Notes:   counter-at-period flag comes from the timer core as an input
`timescale 1ns/1ps
module tpg_ctrl (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Timer core side
	input  wire logic        suspend_i,
	input  wire logic        timer_evt_i,
	input  wire logic        count_at_period_i,
	input  wire logic [1:0]  half_rst_req_i,
	output logic             count_en_o,
	output logic      [1:0]  half_rst_o,
	output logic      [3:0]  pin_gp_o,
	output logic             event_o,
	// Interrupt
	output logic             irq_o,
	// Timer pins, synchronised here
	input  wire logic [3:0]  pins_i
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        rs1;
		logic        rs2;
		logic [31:0] emu;
		logic [31:0] pin;
		logic [3:0]  last;
		logic [4:0]  sts;
		logic [4:0]  en;
		logic        halted;
		logic        ack;
		logic [31:0] dat;
		logic        cnt_en;
		logic [1:0]  hrst;
		logic [3:0]  gp;
		logic        evt;
		logic        irq;
	} tpg_state_t;

	tpg_state_t r;
	tpg_state_t next_r;
	logic       rst_n;
	logic [3:0] pin_s;
	// Synchronised pin levels carried as the shared pin bundle
	tpg_pkg::tpg_pins_t pins_q;
	logic [3:0] edge_hit;
	logic [3:0] src;
	logic [3:0] inv;
	logic [4:0] events;
	logic       wr;
	logic       rd;

	// Merge a write under byte enables, keeping only writable bits
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] sel, input logic [31:0] m);
		logic [31:0] bm;
		bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return ((old & ~bm) | (d & bm)) & m;
	endfunction

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	assign rst_n = r.rs2;

	tpg_sync #(.W(4)) u_sync (
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n),
		.d_i     (pins_i),
		.q_o     (pins_q)
	);
	// Unpack once so the edge logic below stays readable
	assign pin_s = pins_q.pins;

	// Field extraction, pin order lower in, lower out, upper in, upper out
	assign src = {r.pin[tpg_pkg::HI_SRC+1], r.pin[tpg_pkg::HI_SRC],
		r.pin[tpg_pkg::LO_SRC+1], r.pin[tpg_pkg::LO_SRC]};
	assign inv = {r.pin[tpg_pkg::HI_INV+1], r.pin[tpg_pkg::HI_INV],
		r.pin[tpg_pkg::LO_INV+1], r.pin[tpg_pkg::LO_INV]};

	// Edge detection per pin; polarity applies only with source enabled
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_edge
			assign edge_hit[g] = src[g] && (inv[g] ?
				(r.last[g] && !pin_s[g]) :
				(!r.last[g] && pin_s[g]));
		end
	endgenerate

	// Bits 3:0 pin events, bit 4 timer event when no pin source
	assign events = {timer_evt_i && (src == 4'h0), edge_hit};
	// A held request is taken once: a high ack masks the strobe
	assign wr = wb_cyc_i && wb_stb_i && !r.ack && wb_we_i;
	assign rd = wb_cyc_i && wb_stb_i && !r.ack && !wb_we_i;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r      = r;
		next_r.rs1  = 1'b1;
		next_r.rs2  = r.rs1;
		next_r.last = pin_s;
		next_r.ack  = wb_cyc_i && wb_stb_i && !r.ack;
		// Register writes
		if (wr) begin
			case (wb_adr_i)
				tpg_pkg::EMU_OFS: next_r.emu = merge(r.emu, wb_dat_i,
					wb_sel_i, tpg_pkg::EMU_MASK);
				tpg_pkg::PIN_OFS: next_r.pin = merge(r.pin, wb_dat_i,
					wb_sel_i, tpg_pkg::PIN_MASK);
				tpg_pkg::IRQ_EN_OFS: next_r.en = 5'(merge({27'h0, r.en},
					wb_dat_i, wb_sel_i, 32'h0000_001F));
				default: ;
			endcase
		end
		// Write-one clear; a new event in the same cycle wins
		if (wr && wb_adr_i == tpg_pkg::IRQ_CLR_OFS && wb_sel_i[0]) begin
			next_r.sts = r.sts & ~wb_dat_i[4:0];
		end
		next_r.sts = next_r.sts | events;
		// Read mux, unmapped reads zero
		next_r.dat = 32'h0000_0000;
		if (rd) begin
			case (wb_adr_i)
				tpg_pkg::EMU_OFS:     next_r.dat = r.emu;
				tpg_pkg::PIN_OFS:     next_r.dat = r.pin;
				tpg_pkg::IRQ_STS_OFS: next_r.dat = {27'h0, r.sts};
				tpg_pkg::IRQ_EN_OFS:  next_r.dat = {27'h0, r.en};
				default:              next_r.dat = 32'h0000_0000;
			endcase
		end
		// Suspend handling
		if (!suspend_i || r.emu[tpg_pkg::FREE_BIT]) begin
			next_r.halted = 1'b0;
		end else if (!r.emu[tpg_pkg::SOFT_BIT]) begin
			next_r.halted = 1'b1;
		end else if (count_at_period_i) begin
			next_r.halted = 1'b1;
		end
		// Registered enable: the counter sees a stop one cycle after the
		// request, which keeps the output glitch free at the cost of one
		// extra count on entry to a stop
		next_r.cnt_en = !(suspend_i && !r.emu[tpg_pkg::FREE_BIT]
			&& (!r.emu[tpg_pkg::SOFT_BIT] || r.halted
			|| count_at_period_i));
		// Pin function select
		next_r.gp = {r.pin[tpg_pkg::HI_GP+1], r.pin[tpg_pkg::HI_GP],
			r.pin[tpg_pkg::LO_GP+1], r.pin[tpg_pkg::LO_GP]};
		next_r.hrst = half_rst_req_i
			| {|next_r.gp[3:2], |next_r.gp[1:0]};
		next_r.evt = |events;
		next_r.irq = |(next_r.sts & r.en);
	end

	// Reset release chain runs off the raw reset
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign wb_dat_o   = r.dat;
	assign wb_ack_o   = r.ack;
	assign count_en_o = r.cnt_en;
	assign half_rst_o = r.hrst;
	assign pin_gp_o   = r.gp;
	assign event_o    = r.evt;
	assign irq_o      = r.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Suspend modes: run free, stop at once, stop at the period
	free_runs_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		r.emu[tpg_pkg::FREE_BIT] && suspend_i |=> count_en_o)
		else $error("counter stopped in free mode");

	hard_stop_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		suspend_i && r.emu[1:0] == 2'b00 |=> !count_en_o)
		else $error("counter ran in hard stop");

	soft_stop_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		suspend_i && r.emu[1:0] == 2'b10 && count_at_period_i
		|=> !count_en_o)
		else $error("counter passed period in soft stop");

	soft_runs_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		suspend_i && r.emu[1:0] == 2'b10 && !r.halted
		&& !count_at_period_i |=> count_en_o)
		else $error("counter stopped early in soft stop");

	halt_hold_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		suspend_i && r.emu[1:0] == 2'b10 && r.halted |=> !count_en_o)
		else $error("counter restarted in soft stop");

	// Pin function bits reach the outputs one cycle after the register
	gp_out_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		##1 pin_gp_o[3] == $past(r.pin[25]))
		else $error("upper out pin function wrong");

	gp_lo_out_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		##1 pin_gp_o[1] == $past(r.pin[17]))
		else $error("lower out pin function wrong");

	gp_in_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		##1 pin_gp_o[0] == $past(r.pin[16]))
		else $error("lower in pin function wrong");

	gp_up_in_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		##1 pin_gp_o[2] == $past(r.pin[24]))
		else $error("upper in pin function wrong");

	// Edge capture in status; polarity counts only with the source set
	rise_evt_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		r.pin[8] && !r.pin[12] && !r.last[2] && pin_s[2] |=> r.sts[2])
		else $error("rising edge missed");

	fall_up_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		r.pin[9] && r.pin[13] && r.last[3] && !pin_s[3] |=> r.sts[3])
		else $error("upper falling edge missed");

	fall_evt_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		r.pin[0] && r.pin[4] && r.last[0] && !pin_s[0] |=> r.sts[0])
		else $error("falling edge missed");

	rise_lo_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		r.pin[1] && !r.pin[5] && !r.last[1] && pin_s[1] |=> r.sts[1])
		else $error("lower rising edge missed");

	no_src_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		!r.pin[1] && !r.sts[1] && !(wr && wb_adr_i == tpg_pkg::PIN_OFS)
		|=> !r.sts[1])
		else $error("event from disabled pin source");

	upper_quiet_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		!r.pin[9] && !r.sts[3] |=> !r.sts[3])
		else $error("event from disabled upper pin");

	// Timer events count only while no pin is an event source
	timer_src_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		timer_evt_i && (r.pin & 32'h0000_0303) == 32'h0
		|=> event_o && r.sts[4])
		else $error("timer event lost");

	timer_mask_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		r.pin[8] && !r.sts[4] |=> !r.sts[4])
		else $error("timer event while pin sources");

	// Pin use keeps the matching timer half in reset
	hold_rst_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		pin_gp_o[3] |-> half_rst_o[1])
		else $error("upper half released in pin mode");

	hold_lo_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		pin_gp_o[0] |-> half_rst_o[0])
		else $error("lower half released in pin mode");

	// Reserved bits and unmapped reads stay zero
	rsvd_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		(r.pin & ~tpg_pkg::PIN_MASK) == 32'h0 && r.emu[31:2] == 30'h0)
		else $error("reserved bit set");

	rd_zero_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		rd && wb_adr_i > tpg_pkg::IRQ_EN_OFS |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");

	// Bus handshake and sticky status
	ack_once_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	sticky_a: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		r.sts[4] && !(wr && wb_adr_i == tpg_pkg::IRQ_CLR_OFS)
		|=> r.sts[4])
		else $error("status bit lost without clear");

	// Main scenarios that the bench should reach
	wr_cov: cover property (@(posedge core_clk_i) wr && wb_ack_o == 1'b0);
	sus_cov: cover property (@(posedge core_clk_i) suspend_i && !count_en_o);
	irq_cov: cover property (@(posedge core_clk_i) irq_o);
	edge_cov: cover property (@(posedge core_clk_i) |edge_hit);
	halt_cov: cover property (@(posedge core_clk_i) r.halted && suspend_i);
endmodule

/* tb/tpg_pin_model.sv */
// Purpose: board pins and timer counter beside the control block
// Assumes: pins move on the falling edge, away from sampling
// Notes:   counter wraps after the period value
`timescale 1ns/1ps
module tpg_pin_model #(
	parameter int PERIOD = 12
) (
	// Clock and requested pin levels
	input  wire logic       clk_i,
	input  wire logic [3:0] want_i,
	input  wire logic       count_en_i,
	// Pins and counter state
	output logic      [3:0] pins_o = 4'h0,
	output logic            at_period_o,
	output logic      [7:0] cnt_o = 8'h00
);
	// Pins are asynchronous, so they never change on the rising edge
	always @(negedge clk_i) pins_o <= want_i;
	// Counter advances only while the block lets it
	always @(posedge clk_i) begin
		if (count_en_i)
			cnt_o <= (cnt_o == 8'(PERIOD)) ? 8'h00 : cnt_o + 8'h01;
	end
	assign at_period_o = (cnt_o == 8'(PERIOD));
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the timer pin control block
// Assumes: classic Wishbone, one clock at 100 MHz
// Notes:   xorshift stimulus from a fixed seed
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, sus = 0, tev = 0;
	logic [7:0] adr = 8'h00, cnt;
	logic [31:0] wd = 32'h0, rd, q, seed = 32'h24;
	logic ack, cen, ev, irq, atp;
	logic [1:0] hreq = 2'h0, hr;
	logic [3:0] want = 4'h0, pins, gp, sel = 4'hF;
	int errors = 0, checked = 0, cycles = 0, evs = 0;
	always #5 clk = ~clk;
	tpg_ctrl u_dut(.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .suspend_i(sus),
		.timer_evt_i(tev), .count_at_period_i(atp), .half_rst_req_i(hreq),
		.count_en_o(cen), .half_rst_o(hr), .pin_gp_o(gp), .event_o(ev),
		.irq_o(irq), .pins_i(pins));
	tpg_pin_model u_far(.clk_i(clk), .want_i(want), .count_en_i(cen),
		.pins_o(pins), .at_period_o(atp), .cnt_o(cnt));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One classic cycle; held until ack is seen on a rising edge
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rd;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse_evt;
		tev <= 1;
		step(1);
		tev <= 0;
		step(5);
	endtask
	task automatic close_out;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard, well above the run length; also counts event pulses
	always @(posedge clk) begin
		if (ev === 1'b1)
			evs++;
		cycles++;
		if (cycles > 5000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		int b;
		step(8); rst_n <= 1; step(4);
		wb(0, 8'h04, 0); chk(q, 0);
		wb(0, 8'h08, 0); chk(q, 0);
		wb(0, 8'h20, 0); chk(q, 0);
		// Random settings: readback, pin use and held halves
		repeat (6) begin
			seed = xs(seed); hreq <= seed[31:30];
			wb(1, 8'h04, seed); wb(0, 8'h04, 0);
			chk(q, seed & tpg_pkg::EMU_MASK);
			wb(1, 8'h08, seed); wb(0, 8'h08, 0);
			chk(q, seed & tpg_pkg::PIN_MASK);
			chk(32'({seed[25:24], seed[17:16]}), 32'(gp));
			chk(32'(hr), 32'(hreq | {|seed[25:24], |seed[17:16]}));
		end
		// Byte lanes: only the low lane of a masked write lands
		wb(1, 8'h08, tpg_pkg::PIN_MASK); sel <= 4'h1; wb(1, 8'h08, 0);
		sel <= 4'hF; wb(0, 8'h08, 0);
		chk(q, tpg_pkg::PIN_MASK & 32'hFFFF_FF00);
		hreq <= 0; wb(1, 8'h08, 0);
		// Every suspend mode, entered just past the period value
		for (int m = 0; m < 4; m++) begin
			wb(1, 8'h04, 32'(m));
			while (atp !== 1'b1) step(1);
			step(2); sus <= 1; step(3);
			chk(32'(cen), 32'(m != 0));
			step(40);
			chk(32'(cen), 32'(m % 2));
			q = 32'(cnt); step(4);
			chk(32'(cnt != q[7:0]), 32'(m % 2));
			sus <= 0; step(3);
		end
		// Each pin, each edge polarity, as event source
		wb(1, 8'h18, 32'h1F);
		for (int i = 0; i < 4; i++) for (int k = 0; k < 2; k++) begin
			b = (i / 2) * 8 + i % 2;
			wb(1, 8'h08, (32'h1 << b) | (32'(k) << (b + 4)));
			step(6); wb(1, 8'h14, 32'h1F);
			want[i] <= 1; step(6); wb(0, 8'h10, 0);
			chk(q, 32'(k == 0) << i);
			chk(32'(irq), 32'(k == 0));
			wb(1, 8'h14, 32'h1F);
			want[i] <= 0; step(6); wb(0, 8'h10, 0);
			chk(q, 32'(k) << i);
		end
		// Edge selects alone raise nothing; timer events need no source
		wb(1, 8'h08, 32'h3030); wb(1, 8'h14, 32'h1F);
		want <= 4'hF; step(6); want <= 4'h0; step(6);
		wb(0, 8'h10, 0); chk(q, 0);
		b = evs; pulse_evt(); chk(evs - b, 1);
		wb(0, 8'h10, 0); chk(q, 32'h10);
		chk(32'(irq), 1);
		wb(1, 8'h14, 32'h1F); wb(1, 8'h08, 32'h1);
		b = evs; pulse_evt(); chk(evs - b, 0);
		wb(0, 8'h10, 0); chk(q, 0);
		wb(1, 8'h08, 0); wb(1, 8'h18, 0); pulse_evt();
		chk(32'(irq), 0);
		wb(0, 8'h10, 0); chk(q, 32'h10);
		// Mid-run reset clears a register written earlier
		rst_n <= 0; step(2); rst_n <= 1; step(4);
		wb(0, 8'h04, 0); chk(q, tpg_pkg::RST_VAL);
		close_out();
	end
endmodule
